//--- src/emsc_pkg.sv
// package: constants and carrier types of the elevation mirror step control
package emsc_pkg;

  // timing
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned SLEW_HZ           = 50;
  localparam int unsigned SLEW_HALF_CYC_DEF = CLK_HZ / (2 * SLEW_HZ);
  localparam int unsigned DEBOUNCE_MS       = 10;
  localparam int unsigned DEBOUNCE_CYC_DEF  = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned CNT_W             = 20;

  // register byte offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_STEPS  = 4'h8;

  // control fields
  localparam int unsigned CTRL_ZENITH_BIT = 0;
  localparam int unsigned CTRL_STEP_BIT   = 1;
  localparam int unsigned CTRL_HALT_BIT   = 2;
  localparam int unsigned CTRL_LOCK_BIT   = 3;

  // status fields
  localparam int unsigned STAT_SLEW_BIT   = 0;
  localparam int unsigned STAT_REV_BIT    = 1;
  localparam int unsigned STAT_DIR_BIT    = 2;
  localparam int unsigned STAT_BUSY_BIT   = 3;
  localparam int unsigned STAT_SENSOR_BIT = 4;

  // reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [15:0] RST_STEPS = 16'h0000;

  // host lines and zenith sensor, as seen at the pins
  typedef struct packed {
    logic host_direction_cmd;
    logic host_zenith_line;
    logic host_step_line;
    logic zenith_sensor_n;
  } emsc_host_pins_t;

  // manual push buttons, high while pressed
  typedef struct packed {
    logic manual_reverse_button;
    logic manual_zenith_button;
    logic manual_step_button;
  } emsc_buttons_t;

endpackage : emsc_pkg

//--- src/emsc_debounce.sv
// module: two-flop synchroniser and debouncer for one push button
module emsc_debounce
  import emsc_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DEBOUNCE_CYC_DEF
) (
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_button,
  output logic      o_level,
  output logic      o_press
);

  logic             meta_r;
  logic             sync_r;
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= i_button;
      sync_r <= meta_r;
    end
  end

  // level accepted only after it stays put for the whole window
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cnt_r   <= '0;
      o_level <= 1'b0;
      o_press <= 1'b0;
    end else begin
      o_press <= 1'b0;
      if (sync_r == o_level) begin
        cnt_r <= '0;
      end else if (cnt_r >= CNT_W'(STABLE_CYC - 1)) begin
        cnt_r   <= '0;
        o_level <= sync_r;
        o_press <= sync_r;
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

endmodule // emsc_debounce

//--- src/emsc_top.sv
// module: elevation mirror direction, zenith slew and step control
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
module emsc_top
  import emsc_pkg::*;
#(
  parameter int unsigned SLEW_HALF_CYC = SLEW_HALF_CYC_DEF,
  parameter int unsigned DEBOUNCE_CYC  = DEBOUNCE_CYC_DEF
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  // avalon-mm slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // host command lines
  input  wire logic        i_host_direction_cmd,
  input  wire logic        i_host_zenith_line,
  input  wire logic        i_host_step_line,
  // zenith position sensor, low pulse at zenith
  input  wire logic        i_zenith_sensor_n,
  // manual buttons, high while pressed
  input  wire logic        i_manual_reverse_button,
  input  wire logic        i_manual_zenith_button,
  input  wire logic        i_manual_step_button,
  // stepper driver
  output logic             o_motor_dir,
  output logic             o_motor_step
);

  emsc_host_pins_t  pins_w;
  emsc_host_pins_t  pins_meta_r;
  emsc_host_pins_t  pins_sync_r;
  emsc_host_pins_t  pins_prev_r;
  emsc_buttons_t    btn_raw_w;
  emsc_buttons_t    btn_level_w;
  emsc_buttons_t    btn_press_w;

  logic             host_zenith_rise;
  logic             host_step_rise;
  logic             sensor_fall;
  logic             sensor_shot_r;
  logic             reverse_clear_n;
  logic             manual_reverse_ff;
  logic             slew_run_ff;
  logic             slew_set;
  logic             slew_clr;
  logic [CNT_W-1:0] slew_cnt_r;
  logic             slew_clk_r;
  logic             step_busy_r;
  logic [CNT_W-1:0] step_cnt_r;
  logic             step_req;
  logic             step_out_nxt;
  logic [15:0]      steps_r;
  logic             lock_r;
  logic             soft_zenith_r;
  logic             soft_step_r;
  logic             soft_halt_r;
  logic             bus_req;
  logic             bus_ack;
  logic             steps_clr;

  // read-back decode, shared by the read path
  function automatic logic [31:0] read_word(input logic [3:0] addr);
    logic [31:0] w;
    w = RST_WORD;
    if (addr == ADDR_CTRL) begin
      w[CTRL_LOCK_BIT] = lock_r;
    end else if (addr == ADDR_STATUS) begin
      w[STAT_SLEW_BIT]   = slew_run_ff;
      w[STAT_REV_BIT]    = manual_reverse_ff;
      w[STAT_DIR_BIT]    = o_motor_dir;
      w[STAT_BUSY_BIT]   = step_busy_r;
      w[STAT_SENSOR_BIT] = pins_sync_r.zenith_sensor_n;
    end else if (addr == ADDR_STEPS) begin
      w[15:0] = steps_r;
    end else begin
      w = RST_WORD;
    end
    return w;
  endfunction

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  assign pins_w.host_direction_cmd = i_host_direction_cmd;
  assign pins_w.host_zenith_line   = i_host_zenith_line;
  assign pins_w.host_step_line     = i_host_step_line;
  assign pins_w.zenith_sensor_n    = i_zenith_sensor_n;

  // sensor idles high; reset values avoid a false fall at release
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pins_meta_r <= '{default: 1'b0, zenith_sensor_n: 1'b1};
      pins_sync_r <= '{default: 1'b0, zenith_sensor_n: 1'b1};
      pins_prev_r <= '{default: 1'b0, zenith_sensor_n: 1'b1};
    end else begin
      pins_meta_r <= pins_w;
      pins_sync_r <= pins_meta_r;
      pins_prev_r <= pins_sync_r;
    end
  end

  assign host_zenith_rise = pins_sync_r.host_zenith_line & ~pins_prev_r.host_zenith_line;
  assign host_step_rise   = pins_sync_r.host_step_line & ~pins_prev_r.host_step_line;
  assign sensor_fall      = ~pins_sync_r.zenith_sensor_n & pins_prev_r.zenith_sensor_n;

  // one-shot: a single clear pulse per sensor low pulse
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sensor_shot_r <= 1'b0;
    end else begin
      sensor_shot_r <= sensor_fall;
    end
  end

  // ------------------------------------------------------------------
  // manual buttons
  // ------------------------------------------------------------------
  assign btn_raw_w.manual_reverse_button = i_manual_reverse_button;
  assign btn_raw_w.manual_zenith_button  = i_manual_zenith_button;
  assign btn_raw_w.manual_step_button    = i_manual_step_button;

  generate
    for (genvar g = 0; g < 3; g++) begin : g_btn
      emsc_debounce #(
        .STABLE_CYC (DEBOUNCE_CYC)
      ) u_deb (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_button  (btn_raw_w[g]),
        .o_level   (btn_level_w[g]),
        .o_press   (btn_press_w[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // direction
  // ------------------------------------------------------------------
  // idle host keeps both lines low so the clear stays inactive
  assign reverse_clear_n = ~(pins_sync_r.host_zenith_line |
                             pins_sync_r.host_step_line);

  // clear dominates a toggle, as the flop's own clear input does
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      manual_reverse_ff <= 1'b0;
    end else if (!reverse_clear_n) begin
      manual_reverse_ff <= 1'b0;
    end else if (btn_press_w.manual_reverse_button && !lock_r) begin
      manual_reverse_ff <= ~manual_reverse_ff;
    end
  end

  // high level drives the mirror clockwise
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_motor_dir <= 1'b0;
    end else begin
      o_motor_dir <= pins_sync_r.host_direction_cmd ^ manual_reverse_ff;
    end
  end

  // ------------------------------------------------------------------
  // zenith slew
  // ------------------------------------------------------------------
  assign slew_set = host_zenith_rise | soft_zenith_r |
                    (btn_press_w.manual_zenith_button & ~lock_r);
  assign slew_clr = sensor_shot_r | soft_halt_r |
                    (btn_press_w.manual_step_button & ~lock_r);

  // a start request in the stop cycle wins
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      slew_run_ff <= 1'b0;
    end else if (slew_set) begin
      slew_run_ff <= 1'b1;
    end else if (slew_clr) begin
      slew_run_ff <= 1'b0;
    end
  end

  // free-running 50 Hz square wave, gated later
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      slew_cnt_r <= '0;
      slew_clk_r <= 1'b0;
    end else if (slew_cnt_r >= CNT_W'(SLEW_HALF_CYC - 1)) begin
      slew_cnt_r <= '0;
      slew_clk_r <= ~slew_clk_r;
    end else begin
      slew_cnt_r <= slew_cnt_r + CNT_W'(1);
    end
  end

  // ------------------------------------------------------------------
  // single step
  // ------------------------------------------------------------------
  // a press during a slew only stops it; a press while a step is
  // still high is dropped so each accepted press is one step
  assign step_req = ~slew_run_ff & ~step_busy_r & ~slew_set &
                    ((btn_press_w.manual_step_button & ~lock_r) |
                     host_step_rise | soft_step_r);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      step_busy_r <= 1'b0;
      step_cnt_r  <= '0;
    end else if (step_req) begin
      step_busy_r <= 1'b1;
      step_cnt_r  <= '0;
    end else if (step_busy_r) begin
      if (step_cnt_r >= CNT_W'(SLEW_HALF_CYC - 1)) begin
        step_busy_r <= 1'b0;
        step_cnt_r  <= '0;
      end else begin
        step_cnt_r <= step_cnt_r + CNT_W'(1);
      end
    end
  end

  assign step_out_nxt = (slew_clk_r & slew_run_ff) ^ step_busy_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_motor_step <= 1'b0;
    end else begin
      o_motor_step <= step_out_nxt;
    end
  end

  // rising step edges seen by the driver; wraps at 16 bits
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      steps_r <= RST_STEPS;
    end else if (step_out_nxt && !o_motor_step) begin
      steps_r <= steps_clr ? 16'h0001 : steps_r + 16'h0001;
    end else if (steps_clr) begin
      steps_r <= RST_STEPS;
    end
  end

  // ------------------------------------------------------------------
  // avalon-mm slave, one wait state on every access
  // ------------------------------------------------------------------
  assign bus_req   = i_avs_read | i_avs_write;
  assign bus_ack   = bus_req & ~o_avs_waitrequest;
  assign steps_clr = bus_ack & i_avs_write & (i_avs_address == ADDR_STEPS);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else if (bus_req && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // data is latched one cycle ahead so it stands with waitrequest low
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_avs_readdata <= RST_WORD;
    end else if (i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= read_word(i_avs_address);
    end else begin
      // back to zero in the cycle after the answer, waitrequest high again
      o_avs_readdata <= RST_WORD;
    end
  end

  // zenith, step and halt bits are self-clearing one-cycle strobes; the lock bit holds its value
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      lock_r        <= 1'b0;
      soft_zenith_r <= 1'b0;
      soft_step_r   <= 1'b0;
      soft_halt_r   <= 1'b0;
    end else begin
      soft_zenith_r <= 1'b0;
      soft_step_r   <= 1'b0;
      soft_halt_r   <= 1'b0;
      if (bus_ack && i_avs_write && (i_avs_address == ADDR_CTRL)) begin
        lock_r        <= i_avs_writedata[CTRL_LOCK_BIT];
        soft_zenith_r <= i_avs_writedata[CTRL_ZENITH_BIT];
        soft_step_r   <= i_avs_writedata[CTRL_STEP_BIT];
        soft_halt_r   <= i_avs_writedata[CTRL_HALT_BIT];
      end
    end
  end

endmodule // emsc_top

//--- bench/emsc_asserts.sv
// checker: port assertions of the mirror step control
module emsc_asserts
  import emsc_pkg::*;
#(
  parameter int unsigned SLEW_HALF_CYC = 8,
  parameter int unsigned DEBOUNCE_CYC  = 4
) (
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_host_direction_cmd,
  input wire logic        i_host_zenith_line,
  input wire logic        i_host_step_line,
  input wire logic        i_zenith_sensor_n,
  input wire logic        i_manual_reverse_button,
  input wire logic        i_manual_zenith_button,
  input wire logic        i_manual_step_button,
  input wire logic        o_motor_dir,
  input wire logic        o_motor_step
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  int unsigned hi_cnt_r;
  // length of the current high phase of the step line
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || !o_motor_step) hi_cnt_r <= 0;
    else hi_cnt_r <= hi_cnt_r + 1;
  end
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_quiet;
    !i_manual_reverse_button && !i_host_zenith_line && !i_host_step_line
      && $stable(i_host_direction_cmd);
  endsequence
  property p_rst;
    disable iff (1'b0) i_sys_rst |=> o_avs_waitrequest && !o_motor_step && !o_motor_dir;
  endproperty
  property p_req;
    s_req |=> !o_avs_waitrequest;
  endproperty
  property p_wait1;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  property p_rdz;
    o_avs_waitrequest |-> o_avs_readdata == 32'h0000_0000;
  endproperty
  // clear is a level, so a held host line pins direction to the command
  property p_dir_follow;
    (i_host_step_line && $stable(i_host_direction_cmd)) [*7]
      |-> o_motor_dir == i_host_direction_cmd;
  endproperty
  property p_quiet;
    s_quiet [*8] |-> ##2 $stable(o_motor_dir);
  endproperty
  property p_zen_go;
    $rose(i_host_zenith_line) |-> ##[3:24] o_motor_step;
  endproperty
  property p_stop;
    $fell(i_zenith_sensor_n) && !i_host_zenith_line |-> ##6 (!o_motor_step) [*8];
  endproperty
  property p_step_hi;
    o_motor_step |-> hi_cnt_r < SLEW_HALF_CYC;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle in reset");
  a_req: assert property (p_req) else $error("request not answered next cycle");
  a_wait1: assert property (p_wait1) else $error("waitrequest low too long");
  a_rdz: assert property (p_rdz) else $error("readdata not zero while waiting");
  a_dir_follow: assert property (p_dir_follow)
    else $error("direction not following host command");
  a_quiet: assert property (p_quiet)
    else $error("direction moved without cause");
  a_zen_go: assert property (p_zen_go)
    else $error("zenith pulse gave no step");
  a_stop: assert property (p_stop)
    else $error("sensor did not stop the slew");
  a_step_hi: assert property (p_step_hi)
    else $error("step high too long");
endmodule // emsc_asserts

bind emsc_top emsc_asserts #(
  .SLEW_HALF_CYC(SLEW_HALF_CYC),
  .DEBOUNCE_CYC (DEBOUNCE_CYC)
) emsc_asserts_i (
  .i_ref_clk, .i_sys_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .o_avs_readdata, .o_avs_waitrequest, .i_host_direction_cmd, .i_host_zenith_line,
  .i_host_step_line, .i_zenith_sensor_n, .i_manual_reverse_button,
  .i_manual_zenith_button, .i_manual_step_button, .o_motor_dir, .o_motor_step
);

//--- bench/emsc_motor_model.sv
// partner: stepper driver with a zenith sensor at a fixed position
module emsc_motor_model #(
  parameter int ZEN_POS = 5
) (
  input  wire logic i_ref_clk,
  input  wire logic i_motor_dir,
  input  wire logic i_motor_step,
  output logic      o_zenith_sensor_n,
  output int        o_pos
);
  timeunit 1ns;
  timeprecision 1ns;
  logic step_q  = 1'b0;
  int   pos_r   = 0;
  int   low_cnt = 0;
  // one step per rising edge, sign from the direction level
  always @(posedge i_ref_clk) begin
    step_q <= i_motor_step;
    if (i_motor_step && !step_q) begin
      pos_r <= i_motor_dir ? pos_r + 1 : pos_r - 1;
      if ((i_motor_dir ? pos_r + 1 : pos_r - 1) == ZEN_POS) low_cnt <= 3;
    end else if (low_cnt > 0) begin
      low_cnt <= low_cnt - 1;
    end
  end
  assign o_zenith_sensor_n = (low_cnt == 0);
  assign o_pos = pos_r;
endmodule // emsc_motor_model

//--- bench/tb_top.sv
// testbench: mirror step control against a behavioural model
module tb_top
  import emsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HC = 8;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic [3:0]      adr = 4'h0;
  logic            rd  = 1'b0;
  logic            wr  = 1'b0;
  logic [31:0]     wd  = 32'h0000_0000;
  logic [31:0]     rdata, q;
  logic            waitr, mdir, mstep, sens_n;
  emsc_host_pins_t hp  = '0;
  emsc_buttons_t   bt  = '0;
  int              pos, failures, cmp_count, m_rev, m_hd, m_steps, m_pos;

  emsc_top #(.SLEW_HALF_CYC(HC), .DEBOUNCE_CYC(4)) emsc_top_i (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitr), .i_host_direction_cmd(hp.host_direction_cmd),
    .i_host_zenith_line(hp.host_zenith_line), .i_host_step_line(hp.host_step_line),
    .i_zenith_sensor_n(sens_n), .i_manual_reverse_button(bt.manual_reverse_button),
    .i_manual_zenith_button(bt.manual_zenith_button),
    .i_manual_step_button(bt.manual_step_button), .o_motor_dir(mdir), .o_motor_step(mstep));
  emsc_motor_model emsc_motor_model_i (.i_ref_clk(clk), .i_motor_dir(mdir),
    .i_motor_step(mstep), .o_zenith_sensor_n(sens_n), .o_pos(pos));

  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // waits for the answer, only the watchdog bounds a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do @(posedge clk); while (waitr !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic hpulse(input bit zen);
    @(posedge clk);
    if (zen) hp.host_zenith_line <= 1'b1;
    else hp.host_step_line <= 1'b1;
    cyc(8);
    hp.host_zenith_line <= 1'b0;
    hp.host_step_line   <= 1'b0;
    m_rev = 0;
    cyc(3 * HC);
  endtask
  task automatic press(input int k);
    @(posedge clk);
    bt[k] <= 1'b1;
    cyc(10);
    bt[k] <= 1'b0;
    cyc(3 * HC);
  endtask
  function automatic logic [31:0] stat();
    return 32'h0000_0010 | 32'((m_hd ^ m_rev) << STAT_DIR_BIT) | 32'(m_rev << STAT_REV_BIT);
  endfunction
  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    failures++;
    close_out();
  end
  initial begin
    void'($urandom(11));
    cyc(20);
    rst <= 1'b0;
    cyc(4);
    bus(0, ADDR_STEPS, 0);
    chk("steps", q, {16'h0000, RST_STEPS});
    bus(0, ADDR_STATUS, 0);
    chk("status", q, stat());
    bus(1, 4'hC, $urandom);
    bus(0, 4'hC, 0);
    chk("hole", q, 32'h0000_0000);
    $display("test reset done");
    hp.host_direction_cmd <= 1'b1;
    m_hd = 1;
    hpulse(1);
    cyc(14 * HC);
    m_pos = 5;
    m_steps = 5;
    chk("pos", pos, m_pos);
    bus(0, ADDR_STEPS, 0);
    chk("steps", q, m_steps);
    bus(0, ADDR_STATUS, 0);
    chk("status", q, stat());
    bus(1, ADDR_STEPS, $urandom);
    m_steps = 0;
    $display("test slew done");
    hp.host_direction_cmd <= 1'b0;
    m_hd = 0;
    hpulse(0);
    press(0);
    m_pos -= 2;
    m_steps += 2;
    chk("pos", pos, m_pos);
    bus(0, ADDR_STEPS, 0);
    chk("steps", q, m_steps);
    $display("test steps done");
    for (int i = 0; i < 6; i++) begin
      m_hd = $urandom % 2;
      hp.host_direction_cmd <= m_hd[0];
      if (i == 0 || $urandom % 2 == 1) begin
        press(2);
        m_rev ^= 1;
      end
      cyc(8);
      chk("dir", mdir, m_hd ^ m_rev);
    end
    bus(0, ADDR_STATUS, 0);
    chk("status", q, stat());
    if (m_rev == 0) begin
      press(2);
      m_rev = 1;
    end
    hp.host_direction_cmd <= 1'b0;
    m_hd = 0;
    hpulse(0);
    chk("dir", mdir, 1'b0);
    $display("test direction done");
    // lock holds the buttons off, host lines still work
    bus(1, ADDR_CTRL, 32'h0000_0008);
    bus(0, ADDR_CTRL, 0);
    chk("ctrl", q, 32'h0000_0008);
    press(2);
    chk("dir", mdir, 1'b0);
    bus(1, ADDR_CTRL, 0);
    $display("test lock done");
    press(1);
    press(0);
    cyc(20);
    bus(0, ADDR_STATUS, 0);
    chk("status", q, stat());
    $display("test manual stop done");
    close_out();
  end
endmodule // tb_top
